// ==== core/cdlr_pkg.sv ====
// Contract
// - Drive enable bit 0 lets both external outputs drive; clear leaves them undriven.
// - With drive enable bits 1 and 2 clear, the processor flag and gp lines are not driven.
// - On nonzero board revisions, output one source code 2 sends the processor serial transmit line to output one.
// - Output two source code 3 sends the processor gp line to output two as transmit enable.
// - On nonzero board revisions, with bit 4 of the flag source register clear, input one feeds the serial receive line.
// - Start tag source 0 produces no start tag.
// - Second tag source 0 produces no second tag.
// - On nonzero board revisions a 10 s reset button hold selects boot with watchdog off.
// - Codes: 0 low, 1 high, 2 flag/tx, 3 gp, 4/5 inputs, 6 start, 7 second, 8 up reserved.
package cdlr_pkg;
  localparam longint CLK_HZ = 100_000_000;
  localparam longint HOLD_TIME_S = 10;
  localparam longint SECOND_TIME_S = 1;
  localparam int CNT_W = 32;
  localparam logic [CNT_W-1:0] HOLD_CYCLES_DEF = CNT_W'(HOLD_TIME_S * CLK_HZ);
  localparam logic [CNT_W-1:0] SECOND_CYCLES_DEF = CNT_W'(SECOND_TIME_S * CLK_HZ);

  localparam int ADDR_W = 12;
  localparam int REV_W = 4;
  localparam logic [9:0] IDX_DRIVE = 10'h009;
  localparam logic [9:0] IDX_OUT_ONE = 10'h00A;
  localparam logic [9:0] IDX_OUT_TWO = 10'h00B;
  localparam logic [9:0] IDX_FLAG = 10'h00C;
  localparam logic [9:0] IDX_GP = 10'h00D;
  localparam logic [9:0] IDX_START = 10'h00E;
  localparam logic [9:0] IDX_SEC = 10'h00F;

  localparam int EN_EXT_BIT = 0;
  localparam int EN_FLAG_BIT = 1;
  localparam int EN_GP_BIT = 2;
  localparam int FLAG_SRC_BIT = 0;
  localparam int RX_SRC_BIT = 4;
  localparam int GP_SRC_BIT = 0;

  localparam logic [7:0] SRC_LOW = 8'h00;
  localparam logic [7:0] SRC_HIGH = 8'h01;
  localparam logic [7:0] SRC_FLAG = 8'h02;
  localparam logic [7:0] SRC_GP = 8'h03;
  localparam logic [7:0] SRC_IN_ONE = 8'h04;
  localparam logic [7:0] SRC_IN_TWO = 8'h05;
  localparam logic [7:0] SRC_START = 8'h06;
  localparam logic [7:0] SRC_SECOND = 8'h07;

  localparam logic [7:0] TAG_OFF = 8'h00;
  localparam logic [7:0] TAG_ONE_RISE = 8'h01;
  localparam logic [7:0] TAG_ONE_FALL = 8'h02;
  localparam logic [7:0] TAG_TWO_RISE = 8'h03;
  localparam logic [7:0] TAG_TWO_FALL = 8'h04;
  localparam logic [7:0] TAG_ON_WRITE = 8'h05;
  localparam logic [7:0] TAG_PERIODIC = 8'h06;

  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;

  typedef struct packed {
    logic [7:0] drive_en;
    logic [7:0] out_one_src;
    logic [7:0] out_two_src;
    logic [7:0] flag_src;
    logic [7:0] gp_src;
    logic [7:0] start_tag_source;
    logic [7:0] sec_src;
  } cdlr_cfg_type;

  typedef struct packed {
    logic in_one;
    logic in_two;
    logic rise_one;
    logic fall_one;
    logic rise_two;
    logic fall_two;
  } cdlr_inputs_type;
endpackage

// ==== core/cdlr_router.sv ====
// The implementer's own choice: register access over APB.
`timescale 1ns/100ps
module cdlr_router
  import cdlr_pkg::*;
#(
  parameter logic [CNT_W-1:0] HOLD_CYCLES = HOLD_CYCLES_DEF,
  parameter logic [CNT_W-1:0] SECOND_CYCLES = SECOND_CYCLES_DEF
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic external_input_one,
  input wire logic external_input_two,
  output logic external_output_one,
  output logic external_output_one_oe,
  output logic external_output_two,
  output logic external_output_two_oe,
  input wire logic processor_serial_transmit,
  input wire logic processor_gp_line_in,
  input wire logic processor_flag_alt_line_in,
  output logic processor_flag_line_out,
  output logic processor_flag_line_oe,
  output logic processor_flag_alt_line_out,
  output logic processor_flag_alt_line_oe,
  output logic processor_gp_line_out,
  output logic processor_gp_line_oe,
  output logic processor_serial_rx_line,
  output logic start_tag_pulse,
  output logic second_tag_pulse,
  input wire logic [REV_W-1:0] board_revision,
  input wire logic reset_button_n,
  output logic watchdog_disable
);

  cdlr_cfg_type cfg_q;
  cdlr_inputs_type in_s;
  logic [1:0] in_one_sync_q, in_two_sync_q, tx_sync_q, gp_sync_q, alt_sync_q, btn_sync_q;
  logic [REV_W-1:0] rev_s1_q, rev_s2_q;
  logic in_one_prev_q, in_two_prev_q;
  logic rev_ok_q, rev_loaded_q;
  logic [CNT_W-1:0] hold_cnt_q, sec_cnt_q;
  logic [31:0] prdata_q;
  logic pready_q, pslverr_q;
  logic [9:0] idx;
  logic hit, wr_en, sec_tick, flag_value, flag_src_val;

  // Bus decode: word-aligned indices only
  assign idx = paddr[ADDR_W-1:2];
  assign hit = (paddr[1:0] == 2'b00) && (idx >= IDX_DRIVE) && (idx <= IDX_SEC);
  assign wr_en = psel && penable && pready_q && pwrite && pstrb[0] && hit;

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= READ_ZERO;
    end else begin
      pready_q <= psel && !penable;
      pslverr_q <= psel && !penable && !hit;
      prdata_q <= READ_ZERO;
    end
  end

  // Routing registers, write only
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      cfg_q <= '{default: RST_BYTE};
    end else if (wr_en) begin
      unique case (idx)
        IDX_DRIVE: cfg_q.drive_en <= pwdata[7:0];
        IDX_OUT_ONE: cfg_q.out_one_src <= pwdata[7:0];
        IDX_OUT_TWO: cfg_q.out_two_src <= pwdata[7:0];
        IDX_FLAG: cfg_q.flag_src <= pwdata[7:0];
        IDX_GP: cfg_q.gp_src <= pwdata[7:0];
        IDX_START: cfg_q.start_tag_source <= pwdata[7:0];
        IDX_SEC: cfg_q.sec_src <= pwdata[7:0];
        default: cfg_q <= cfg_q;
      endcase
    end
  end

  // Pin synchronisers, kept out of reset so they flush to the pin levels
  // Avoids a false edge and a stale board revision right after release
  always_ff @(posedge sys_clk) begin
    in_one_sync_q <= {in_one_sync_q[0], external_input_one};
    in_two_sync_q <= {in_two_sync_q[0], external_input_two};
    tx_sync_q <= {tx_sync_q[0], processor_serial_transmit};
    gp_sync_q <= {gp_sync_q[0], processor_gp_line_in};
    alt_sync_q <= {alt_sync_q[0], processor_flag_alt_line_in};
    btn_sync_q <= {btn_sync_q[0], reset_button_n};
    rev_s1_q <= board_revision;
    rev_s2_q <= rev_s1_q;
    in_one_prev_q <= in_one_sync_q[1];
    in_two_prev_q <= in_two_sync_q[1];
  end

  assign in_s.in_one = in_one_sync_q[1];
  assign in_s.in_two = in_two_sync_q[1];
  assign in_s.rise_one = in_one_sync_q[1] && !in_one_prev_q;
  assign in_s.fall_one = !in_one_sync_q[1] && in_one_prev_q;
  assign in_s.rise_two = in_two_sync_q[1] && !in_two_prev_q;
  assign in_s.fall_two = !in_two_sync_q[1] && in_two_prev_q;

  // Board revision caught once after release
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      rev_ok_q <= 1'b0;
      rev_loaded_q <= 1'b0;
    end else if (!rev_loaded_q) begin
      rev_ok_q <= |rev_s2_q;
      rev_loaded_q <= 1'b1;
    end
  end

  function automatic logic tag_event(input logic [7:0] code, input cdlr_inputs_type s,
                                     input logic wr_self, input logic tick);
    logic r;
    r = 1'b0;
    unique case (code)
      TAG_ONE_RISE: r = s.rise_one;
      TAG_ONE_FALL: r = s.fall_one;
      TAG_TWO_RISE: r = s.rise_two;
      TAG_TWO_FALL: r = s.fall_two;
      TAG_ON_WRITE: r = wr_self;
      TAG_PERIODIC: r = tick;
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  // One-second period, phase taken from the write
  assign sec_tick = (cfg_q.sec_src == TAG_PERIODIC) && (sec_cnt_q == SECOND_CYCLES - 1'b1);

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      sec_cnt_q <= '0;
    end else if ((wr_en && idx == IDX_SEC) || cfg_q.sec_src != TAG_PERIODIC || sec_tick) begin
      sec_cnt_q <= '0;
    end else begin
      sec_cnt_q <= sec_cnt_q + 1'b1;
    end
  end

  // Write-triggered tags fire one clock after the setting lands
  logic start_wr_q, sec_wr_q;
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      start_wr_q <= 1'b0;
      sec_wr_q <= 1'b0;
      start_tag_pulse <= 1'b0;
      second_tag_pulse <= 1'b0;
    end else begin
      start_wr_q <= wr_en && (idx == IDX_START);
      sec_wr_q <= wr_en && (idx == IDX_SEC);
      start_tag_pulse <= tag_event(cfg_q.start_tag_source, in_s, start_wr_q, 1'b0);
      second_tag_pulse <= tag_event(cfg_q.sec_src, in_s, sec_wr_q, sec_tick);
    end
  end

  function automatic logic route(input logic [7:0] code, input logic flag_in,
                                 input logic gp_in, input cdlr_inputs_type s,
                                 input logic st, input logic sc);
    logic r;
    r = 1'b0;
    unique case (code)
      SRC_LOW: r = 1'b0;
      SRC_HIGH: r = 1'b1;
      SRC_FLAG: r = flag_in;
      SRC_GP: r = gp_in;
      SRC_IN_ONE: r = s.in_one;
      SRC_IN_TWO: r = s.in_two;
      SRC_START: r = st;
      SRC_SECOND: r = sc;
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  // Code 2 takes the transmit line on newer boards, the alternate flag line otherwise
  assign flag_src_val = rev_ok_q ? tx_sync_q[1] : alt_sync_q[1];
  assign flag_value = cfg_q.flag_src[FLAG_SRC_BIT] ? in_s.in_two : in_s.in_one;

  // Every route is registered so unchanged routes hold steady across writes
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      external_output_one <= 1'b0;
      external_output_two <= 1'b0;
      external_output_one_oe <= 1'b0;
      external_output_two_oe <= 1'b0;
      processor_flag_line_out <= 1'b0;
      processor_flag_line_oe <= 1'b0;
      processor_flag_alt_line_out <= 1'b0;
      processor_flag_alt_line_oe <= 1'b0;
      processor_gp_line_out <= 1'b0;
      processor_gp_line_oe <= 1'b0;
      processor_serial_rx_line <= 1'b1;
    end else begin
      external_output_one <= route(cfg_q.out_one_src, flag_src_val, gp_sync_q[1], in_s,
                                   start_tag_pulse, second_tag_pulse);
      external_output_two <= route(cfg_q.out_two_src, flag_src_val, gp_sync_q[1], in_s,
                                   start_tag_pulse, second_tag_pulse);
      external_output_one_oe <= cfg_q.drive_en[EN_EXT_BIT];
      external_output_two_oe <= cfg_q.drive_en[EN_EXT_BIT];
      processor_flag_line_out <= flag_value;
      processor_flag_line_oe <= cfg_q.drive_en[EN_FLAG_BIT] && rev_ok_q;
      processor_flag_alt_line_out <= flag_value;
      processor_flag_alt_line_oe <= cfg_q.drive_en[EN_FLAG_BIT] && !rev_ok_q;
      processor_gp_line_out <= cfg_q.gp_src[GP_SRC_BIT] ? in_s.in_two : in_s.in_one;
      processor_gp_line_oe <= cfg_q.drive_en[EN_GP_BIT];
      if (rev_ok_q) begin
        processor_serial_rx_line <= cfg_q.flag_src[RX_SRC_BIT] ? in_s.in_two : in_s.in_one;
      end else begin
        processor_serial_rx_line <= 1'b1;
      end
    end
  end

  // Long reset button hold selects the watchdog-free boot on nonzero board revisions
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      hold_cnt_q <= '0;
      watchdog_disable <= 1'b0;
    end else if (btn_sync_q[1]) begin
      hold_cnt_q <= '0;
    end else if (hold_cnt_q != HOLD_CYCLES - 1'b1) begin
      hold_cnt_q <= hold_cnt_q + 1'b1;
    end else if (rev_ok_q) begin
      watchdog_disable <= 1'b1;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

  logic wr_drive;
  assign wr_drive = wr_en && (idx == IDX_DRIVE);

  ext_oe_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    wr_drive |=> ##1 (external_output_one_oe == $past(pwdata[EN_EXT_BIT], 2)
                      && external_output_two_oe == external_output_one_oe))
    else $error("external drive enable does not follow register");
  flag_off_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !cfg_q.drive_en[EN_FLAG_BIT] |=> !processor_flag_line_oe && !processor_flag_alt_line_oe)
    else $error("flag line driven while disabled");
  gp_off_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !cfg_q.drive_en[EN_GP_BIT] |=> !processor_gp_line_oe)
    else $error("gp line driven while disabled");
  tx_route_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (cfg_q.out_one_src == SRC_FLAG && rev_ok_q) |=> external_output_one == $past(tx_sync_q[1]))
    else $error("transmit not routed to output one");
  gp_route_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    cfg_q.out_two_src == SRC_GP |=> external_output_two == $past(gp_sync_q[1]))
    else $error("gp line not routed to output two");
  rx_route_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (rev_ok_q && !cfg_q.flag_src[RX_SRC_BIT]) |=> processor_serial_rx_line == $past(in_s.in_one))
    else $error("input one not forwarded to serial receive");
  start_off_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    cfg_q.start_tag_source == TAG_OFF |=> !start_tag_pulse)
    else $error("start tag while disabled");
  sec_off_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    cfg_q.sec_src == TAG_OFF |=> !second_tag_pulse)
    else $error("second tag while disabled");
  hold_boot_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    $rose(watchdog_disable) |-> $past(rev_ok_q) && !$past(btn_sync_q[1])
                                && $past(hold_cnt_q) == HOLD_CYCLES - 1'b1)
    else $error("watchdog disabled without full hold");
  reserved_low_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    cfg_q.out_one_src > SRC_SECOND |=> !external_output_one)
    else $error("reserved source code not low");
  route_latency_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (wr_en && idx == IDX_OUT_TWO && pwdata[7:0] == SRC_HIGH) |=> ##1 external_output_two)
    else $error("route write not applied in two clocks");
  two_reserved_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    cfg_q.out_two_src > SRC_SECOND |=> !external_output_two)
    else $error("reserved source code not low on output two");
  start_route_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    cfg_q.out_one_src == SRC_START |=> external_output_one == $past(start_tag_pulse))
    else $error("start tag not routed to output one");
  second_route_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    cfg_q.out_two_src == SRC_SECOND |=> external_output_two == $past(second_tag_pulse))
    else $error("second tag not routed to output two");
  old_board_wd_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !rev_ok_q |-> !watchdog_disable)
    else $error("watchdog disabled on revision zero board");

  drive_write_c: cover property (@(posedge sys_clk) disable iff (!reset_n) wr_drive);
  start_tag_c: cover property (@(posedge sys_clk) disable iff (!reset_n) start_tag_pulse);
  second_tag_c: cover property (@(posedge sys_clk) disable iff (!reset_n) second_tag_pulse);
  boot_hold_c: cover property (@(posedge sys_clk) disable iff (!reset_n) $rose(watchdog_disable));
  periodic_tick_c: cover property (@(posedge sys_clk) disable iff (!reset_n) sec_tick);

endmodule // cdlr_router

// ==== sim/cdlr_host_model.sv ====
`timescale 1ns/100ps
module cdlr_host_model
  import cdlr_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic send,
  input wire logic [7:0] tx_byte,
  input wire logic rs422_mode,
  input wire logic processor_gp_line_out,
  input wire logic processor_gp_line_oe,
  input wire logic processor_flag_alt_line_out,
  input wire logic processor_flag_alt_line_oe,
  output logic processor_serial_transmit,
  output logic processor_gp_line_in,
  output logic processor_flag_alt_line_in,
  output logic busy
);
  logic [9:0] frame_q;
  logic [6:0] cnt_q;

  // Serial frame, eight clocks per bit: start, data lsb first, stop
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      frame_q <= 10'h3FF;
      cnt_q <= 7'h00;
      busy <= 1'b0;
    end else if (send && !busy) begin
      frame_q <= {1'b1, tx_byte, 1'b0};
      cnt_q <= 7'h50;
      busy <= 1'b1;
    end else if (busy) begin
      cnt_q <= cnt_q - 7'h01;
      if (cnt_q[2:0] == 3'h1) frame_q <= {1'b1, frame_q[9:1]};
      if (cnt_q == 7'h01) busy <= 1'b0;
    end
  end

  assign processor_serial_transmit = frame_q[0];
  // Port turns to input while the router drives it
  assign processor_gp_line_in = processor_gp_line_oe ? processor_gp_line_out :
                                (busy | rs422_mode);
  assign processor_flag_alt_line_in = processor_flag_alt_line_oe ?
                                      processor_flag_alt_line_out : 1'b1;
endmodule // cdlr_host_model

// ==== sim/testbench.sv ====
`timescale 1ns/100ps
module testbench;
  import cdlr_pkg::*;
  logic sys_clk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic [3:0] pstrb = 4'hF;
  logic pready, pslverr, in_one = 1'b1, in_two = 1'b0, tx, gp_in, alt_in;
  logic out_one, one_oe, out_two, two_oe, flag_out, flag_oe, alt_out, alt_oe;
  logic gp_out, gp_oe, rx_line, st_p, sc_p, btn_n = 1'b1, wd_dis;
  logic send = 1'b0, rs422 = 1'b0, busy;
  logic [7:0] tx_byte = 8'h00;
  logic [3:0] ht = 4'h0, hg = 4'h0, rev = 4'h1;
  int bad_count = 0, n_tests = 0, cyc = 0;

  cdlr_router #(.HOLD_CYCLES(32'h14), .SECOND_CYCLES(32'h10)) i_cdlr_router (
    .sys_clk(sys_clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .external_input_one(in_one), .external_input_two(in_two),
    .external_output_one(out_one), .external_output_one_oe(one_oe),
    .external_output_two(out_two), .external_output_two_oe(two_oe),
    .processor_serial_transmit(tx), .processor_gp_line_in(gp_in),
    .processor_flag_alt_line_in(alt_in), .processor_flag_line_out(flag_out),
    .processor_flag_line_oe(flag_oe), .processor_flag_alt_line_out(alt_out),
    .processor_flag_alt_line_oe(alt_oe), .processor_gp_line_out(gp_out),
    .processor_gp_line_oe(gp_oe), .processor_serial_rx_line(rx_line),
    .start_tag_pulse(st_p), .second_tag_pulse(sc_p), .board_revision(rev),
    .reset_button_n(btn_n), .watchdog_disable(wd_dis));

  cdlr_host_model i_cdlr_host_model (
    .sys_clk(sys_clk), .reset_n(reset_n), .send(send), .tx_byte(tx_byte),
    .rs422_mode(rs422), .processor_gp_line_out(gp_out), .processor_gp_line_oe(gp_oe),
    .processor_flag_alt_line_out(alt_out), .processor_flag_alt_line_oe(alt_oe),
    .processor_serial_transmit(tx), .processor_gp_line_in(gp_in),
    .processor_flag_alt_line_in(alt_in), .busy(busy));

  always #5 sys_clk = ~sys_clk;

  always @(posedge sys_clk) begin
    ht <= {ht[2:0], tx};
    hg <= {hg[2:0], gp_in};
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      close_out();
    end
  end

  task automatic close_out;
    $display("Comparisons %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic got, input logic exp, input string m);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask

  task automatic apb(input logic [11:0] a, input logic [7:0] d, input logic w,
                     output logic e, output logic [31:0] r);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    e = pslverr;
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [9:0] i, input logic [7:0] d);
    logic e;
    logic [31:0] r;
    apb({i, 2'b00}, d, 1'b1, e, r);
    chk(e, 1'b0, "write refused");
    repeat (3) @(posedge sys_clk);
  endtask

  task automatic cnt(input int n, output int s, output int c, output int o);
    s = 0;
    c = 0;
    o = 0;
    repeat (n) begin
      @(posedge sys_clk);
      s += (st_p === 1'b1);
      c += (sc_p === 1'b1);
      o += (out_one === 1'b1);
      o += (out_two === 1'b1);
    end
  endtask

  task automatic t_reset;
    chk(one_oe, 1'b0, "output one driven");
    chk(flag_oe, 1'b0, "flag line driven");
    chk(gp_oe, 1'b0, "gp line driven");
    chk(rx_line, 1'b1, "rx line not idle high");
    chk(wd_dis, 1'b0, "watchdog off at reset");
    $display("test reset done");
  endtask

  task automatic t_apb;
    logic e;
    logic [31:0] r;
    apb(12'h040, 8'hFF, 1'b1, e, r);
    chk(e, 1'b1, "unmapped write accepted");
    pstrb <= 4'h0;
    apb(12'h024, 8'h01, 1'b1, e, r);
    pstrb <= 4'hF;
    chk(e, 1'b0, "masked write refused");
    apb(12'h025, 8'h01, 1'b1, e, r);
    chk(e, 1'b1, "misaligned write accepted");
    repeat (3) @(posedge sys_clk);
    chk(one_oe, 1'b0, "refused write took effect");
    apb(12'h024, 8'h00, 1'b0, e, r);
    chk(|r, 1'b0, "read data not zero");
    chk(e, 1'b0, "mapped read refused");
    $display("test bus done");
  endtask

  task automatic t_codes;
    logic [7:0] c [5] = '{8'h00, 8'h01, 8'h04, 8'h05, 8'h08};
    logic x [5] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
    in_one <= 1'b1;
    in_two <= 1'b0;
    wr(IDX_DRIVE, 8'h01);
    foreach (c[k]) begin
      wr(IDX_OUT_ONE, c[k]);
      wr(IDX_OUT_TWO, c[k]);
      chk(out_one, x[k], "output one level");
      chk(out_two, x[k], "output two level");
    end
    chk(one_oe, 1'b1, "output one not driven");
    chk(two_oe, 1'b1, "output two not driven");
    wr(IDX_DRIVE, 8'h00);
    chk(one_oe, 1'b0, "output one still driven");
    chk(two_oe, 1'b0, "output two still driven");
    wr(IDX_DRIVE, 8'h06);
    chk(flag_oe, 1'b1, "flag line not driven");
    chk(gp_oe, 1'b1, "gp line not driven");
    chk(alt_oe, 1'b0, "alt flag line driven on new board");
    chk(flag_out, 1'b1, "flag line not from input one");
    chk(gp_out, 1'b1, "gp line not from input one");
    wr(IDX_FLAG, 8'h01);
    wr(IDX_GP, 8'h01);
    chk(flag_out, 1'b0, "flag line not from input two");
    chk(gp_out, 1'b0, "gp line not from input two");
    wr(IDX_DRIVE, 8'h00);
    chk(flag_oe, 1'b0, "flag line still driven");
    chk(gp_oe, 1'b0, "gp line still driven");
    $display("test codes done");
  endtask

  task automatic t_rs485;
    wr(IDX_DRIVE, 8'h01);
    wr(IDX_OUT_ONE, SRC_FLAG);
    wr(IDX_OUT_TWO, SRC_GP);
    tx_byte <= 8'hA5;
    send <= 1'b1;
    @(posedge sys_clk);
    send <= 1'b0;
    repeat (100) begin
      @(posedge sys_clk);
      if (ht[1] == ht[2] && ht[2] == ht[3])
        chk(out_one, ht[2], "transmit path");
      if (hg[1] == hg[2] && hg[2] == hg[3])
        chk(out_two, hg[2], "transmit enable path");
    end
    chk(out_two, 1'b0, "transmitter left on");
    rs422 <= 1'b1;
    repeat (6) @(posedge sys_clk);
    chk(out_two, 1'b1, "four wire enable low");
    rs422 <= 1'b0;
    $display("test serial done");
  endtask

  task automatic t_rx;
    wr(IDX_FLAG, 8'h00);
    in_one <= 1'b0;
    in_two <= 1'b1;
    repeat (5) @(posedge sys_clk);
    chk(rx_line, 1'b0, "rx not from input one");
    in_one <= 1'b1;
    in_two <= 1'b0;
    repeat (5) @(posedge sys_clk);
    chk(rx_line, 1'b1, "rx not from input one");
    wr(IDX_FLAG, 8'h10);
    chk(rx_line, 1'b0, "rx not from input two");
    $display("test receive done");
  endtask

  task automatic t_tags;
    int s, c, o;
    logic e;
    logic [31:0] r;
    wr(IDX_OUT_ONE, SRC_START);
    wr(IDX_OUT_TWO, SRC_SECOND);
    wr(IDX_START, TAG_OFF);
    wr(IDX_SEC, TAG_OFF);
    repeat (3) begin
      in_one <= ~in_one;
      in_two <= ~in_two;
      cnt(8, s, c, o);
      chk(s == 0, 1'b1, "start tag while off");
      chk(c == 0, 1'b1, "second tag while off");
      chk(o == 0, 1'b1, "tag output while off");
    end
    in_one <= 1'b0;
    wr(IDX_START, TAG_ONE_RISE);
    in_one <= 1'b1;
    cnt(8, s, c, o);
    chk(s == 1, 1'b1, "start tag on rise");
    chk(o == 1, 1'b1, "start tag not on output one");
    apb({IDX_SEC, 2'b00}, TAG_ON_WRITE, 1'b1, e, r);
    cnt(6, s, c, o);
    chk(c == 1, 1'b1, "second tag on write");
    chk(o == 1, 1'b1, "second tag not on output two");
    apb({IDX_SEC, 2'b00}, TAG_PERIODIC, 1'b1, e, r);
    cnt(40, s, c, o);
    chk(c == 2, 1'b1, "periodic second tag count");
    chk(o == 2, 1'b1, "periodic tag not on output two");
    wr(IDX_SEC, TAG_OFF);
    cnt(40, s, c, o);
    chk(c == 0, 1'b1, "second tag after off");
    $display("test tags done");
  endtask

  task automatic t_wd;
    btn_n <= 1'b0;
    repeat (10) @(posedge sys_clk);
    btn_n <= 1'b1;
    repeat (6) @(posedge sys_clk);
    chk(wd_dis, 1'b0, "short press disabled watchdog");
    btn_n <= 1'b0;
    repeat (30) @(posedge sys_clk);
    btn_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    chk(wd_dis, 1'b1, "long press ignored");
    $display("test button done");
  endtask

  task automatic t_rev0;
    reset_n <= 1'b0;
    rev <= 4'h0;
    repeat (16) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    chk(wd_dis, 1'b0, "watchdog flag survived reset");
    chk(rx_line, 1'b1, "old board rx line not idle");
    wr(IDX_DRIVE, 8'h02);
    chk(alt_oe, 1'b1, "old board alt flag line not driven");
    chk(flag_oe, 1'b0, "old board flag line driven");
    btn_n <= 1'b0;
    repeat (30) @(posedge sys_clk);
    btn_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    chk(wd_dis, 1'b0, "old board long press disabled watchdog");
    $display("test old board done");
  endtask

  initial begin
    repeat (16) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    t_reset();
    t_apb();
    t_codes();
    t_rs485();
    t_rx();
    t_tags();
    t_wd();
    t_rev0();
    close_out();
  end
endmodule // testbench
